// ### hdl/tc_capcmp.sv
// Input capture and output compare units of a 16-bit timer with an AXI4-Lite slave.
`timescale 1ns/1ps

module tc_capcmp (
  // Clock and reset.
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST,
  // Counter interface from the counter unit.
  input  wire logic [15:0]                I_COUNTER_VALUE,
  input  wire logic                       I_TIMER_TICK,
  input  wire logic                       I_TOP,
  input  wire logic                       I_BOTTOM,
  // Asynchronous trigger sources.
  input  wire logic                       I_CAPTURE_PIN,
  input  wire logic                       I_COMPARATOR_OUTPUT,
  // Interrupt acknowledges from the interrupt controller.
  input  wire logic                       I_CAP_IRQ_ACK,
  input  wire logic                       I_CMPA_IRQ_ACK,
  input  wire logic                       I_CMPB_IRQ_ACK,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]                 I_AWADDR,
  input  wire logic                       I_AWVALID,
  output logic                            O_AWREADY,
  input  wire logic [31:0]                I_WDATA,
  input  wire logic [3:0]                 I_WSTRB,
  input  wire logic                       I_WVALID,
  output logic                            O_WREADY,
  output logic [1:0]                      O_BRESP,
  output logic                            O_BVALID,
  input  wire logic                       I_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [7:0]                 I_ARADDR,
  input  wire logic                       I_ARVALID,
  output logic                            O_ARREADY,
  output logic [31:0]                     O_RDATA,
  output logic [1:0]                      O_RRESP,
  output logic                            O_RVALID,
  input  wire logic                       I_RREADY,
  // Interrupt requests, waveform generator and counter control.
  output logic                            O_CAP_IRQ,
  output logic                            O_CMPA_IRQ,
  output logic                            O_CMPB_IRQ,
  output tc_capcmp_pkg::wave_req_t        O_WAVE_A,
  output tc_capcmp_pkg::wave_req_t        O_WAVE_B,
  output logic                            O_WAVE_TOP,
  output logic                            O_WAVE_BOTTOM,
  output logic [3:0]                      O_WAVEFORM_MODE_SEL,
  output logic [15:0]                     O_CEILING,
  output logic                            O_CNT_WR,
  output logic [15:0]                     O_CNT_WDATA
);

  //----------------------------------------------------------------------------
  // Declarations.
  //----------------------------------------------------------------------------
  logic [15:0] ctrl_reg;            // Control fields.
  logic [2:0]  irq_mask_reg;        // Interrupt enables.
  logic [2:0]  flag_reg;            // Capture and compare flags.
  logic [15:0] capture_register;    // Capture timestamp or ceiling.
  logic [7:0]  high_latch_reg;      // Shared high-byte latch.
  logic [15:0] cmp_active_reg [2];  // Active compare registers.
  logic [15:0] cmp_buf_reg [2];     // Compare buffers.
  logic [1:0]  pin_sync_reg;        // Capture pin synchroniser.
  logic [1:0]  aco_sync_reg;        // Comparator synchroniser.
  logic [2:0]  filt_hist_reg;       // Last three filter samples.
  logic        filt_out_reg;        // Filtered level.
  logic        edge_prev_reg;       // Edge detector memory.
  logic [1:0]  match_pend_reg;      // Match seen, waiting for tick.
  logic        block_reg;           // Counter write blocks next tick.
  logic        aw_hold_reg;         // Write address taken.
  logic        w_hold_reg;          // Write data taken.
  logic [7:0]  aw_addr_reg;         // Held write address.
  logic [31:0] w_data_reg;          // Held write data.
  logic [3:0]  w_strb_reg;          // Held write strobes.
  tc_capcmp_pkg::rd_state_t rd_state_reg; // Read channel state.

  logic [3:0]  mode;                // Waveform mode select.
  logic        cap_ceiling_mode;    // Capture register is the ceiling.
  logic        dbl_buf;             // Compare double buffering active.
  logic        src_level;           // Selected synchronised source.
  logic        edge_in;             // Level presented to the edge detector.
  logic        cap_event;           // Qualified capture in this cycle.
  logic        wr_fire;             // Write performed this cycle.
  logic [7:0]  wr_byte;             // Low byte of the write data.
  logic        rd_fire;             // Read address taken this cycle.
  logic [1:0]  cmp_eq;              // Comparator equality per unit.
  logic [1:0]  cmp_set;             // Compare flag set pulses.

  assign mode             = ctrl_reg[tc_capcmp_pkg::CTRL_MODE_LSB +: 4];
  assign cap_ceiling_mode = (mode == tc_capcmp_pkg::MODE_CTC_CAP) ||
                            (mode == 4'he) || (mode == 4'h8) || (mode == 4'ha);
  assign dbl_buf          = (mode != tc_capcmp_pkg::MODE_NORMAL) &&
                            (mode != tc_capcmp_pkg::MODE_CTC_A) &&
                            (mode != tc_capcmp_pkg::MODE_CTC_CAP); // RULE20
  assign wr_fire          = aw_hold_reg && w_hold_reg && !O_BVALID;
  assign wr_byte          = (w_strb_reg[0]) ? w_data_reg[7:0] : 8'h00;
  assign rd_fire          = I_ARVALID && O_ARREADY;

  //----------------------------------------------------------------------------
  // Trigger path: synchroniser, optional filter, edge detector.
  //----------------------------------------------------------------------------

  // Two flip-flops per source; the pin also carries port-driven levels.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pin_sync_reg <= 2'h0;
      aco_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], I_CAPTURE_PIN};       // RULE7 RULE13
      aco_sync_reg <= {aco_sync_reg[0], I_COMPARATOR_OUTPUT}; // RULE7
    end
  end

  // Source select; a change of source may itself look like an edge.
  assign src_level = ctrl_reg[tc_capcmp_pkg::CTRL_ACS_BIT] ? aco_sync_reg[1]
                                                           : pin_sync_reg[1]; // RULE6

  // Filter samples every system clock; three held samples and the current one must agree.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      filt_hist_reg <= 3'h0;
      filt_out_reg  <= 1'b0;
    end else begin
      filt_hist_reg <= {filt_hist_reg[1:0], src_level};  // RULE11
      if (&{filt_hist_reg, src_level}) begin
        filt_out_reg <= 1'b1;                            // RULE9
      end else if (~|{filt_hist_reg, src_level}) begin
        filt_out_reg <= 1'b0;                            // RULE9
      end
    end
  end

  // The filtered path is four cycles longer than the direct path.
  assign edge_in = ctrl_reg[tc_capcmp_pkg::CTRL_NF_BIT] ? filt_out_reg : src_level; // RULE10

  // Edge detector and capture qualification.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      edge_prev_reg <= 1'b0;
    end else begin
      edge_prev_reg <= edge_in;                          // RULE8
    end
  end

  assign cap_event = !cap_ceiling_mode &&                // RULE12
                     (ctrl_reg[tc_capcmp_pkg::CTRL_EDGE_BIT] ? (edge_in && !edge_prev_reg)
                                                             : (!edge_in && edge_prev_reg));

  //----------------------------------------------------------------------------
  // Compare match and blocking after counter write.
  //----------------------------------------------------------------------------

  assign cmp_eq[0] = (I_COUNTER_VALUE == cmp_active_reg[0]); // RULE16
  assign cmp_eq[1] = (I_COUNTER_VALUE == cmp_active_reg[1]); // RULE16

  // A match found is reported at the next timer tick unless blocked.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      match_pend_reg <= 2'h0;
      block_reg      <= 1'b0;
    end else begin
      if (wr_fire && aw_addr_reg == tc_capcmp_pkg::ADDR_CNT_LOW) begin
        block_reg <= 1'b1;                               // RULE24
      end else if (I_TIMER_TICK) begin
        block_reg <= 1'b0;
      end
      if (I_TIMER_TICK) begin
        match_pend_reg <= block_reg ? 2'h0 : cmp_eq;     // RULE24
      end
    end
  end

  assign cmp_set = I_TIMER_TICK ? match_pend_reg : 2'h0; // RULE16

  //----------------------------------------------------------------------------
  // Flags: hardware set wins over clear by software or acknowledge.
  //----------------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flag_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        logic set_i;
        logic clr_i;
        set_i = (i == 0) ? cap_event : cmp_set[i[0] ? 0 : 1]; // RULE2
        clr_i = (wr_fire && aw_addr_reg == tc_capcmp_pkg::ADDR_FLAGS && wr_byte[i]) ||
                ((i == 0) ? I_CAP_IRQ_ACK : (i == 1) ? I_CMPA_IRQ_ACK : I_CMPB_IRQ_ACK);
        if (set_i) begin
          flag_reg[i] <= 1'b1;
        end else if (clr_i) begin
          flag_reg[i] <= 1'b0;                           // RULE3 RULE17
        end
      end
    end
  end

  // Interrupt outputs come from flip-flops.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_CAP_IRQ  <= 1'b0;
      O_CMPA_IRQ <= 1'b0;
      O_CMPB_IRQ <= 1'b0;
    end else begin
      O_CAP_IRQ  <= flag_reg[0] && irq_mask_reg[0];     // RULE3
      O_CMPA_IRQ <= flag_reg[1] && irq_mask_reg[1];     // RULE17
      O_CMPB_IRQ <= flag_reg[2] && irq_mask_reg[2];     // RULE17
    end
  end

  //----------------------------------------------------------------------------
  // Capture register, shared latch and compare registers.
  //----------------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      capture_register <= 16'h0000;
    end else if (cap_event) begin
      capture_register <= I_COUNTER_VALUE;               // RULE1 RULE14
    end else if (wr_fire && cap_ceiling_mode &&
                 aw_addr_reg == tc_capcmp_pkg::ADDR_CAP_LOW) begin
      capture_register <= {high_latch_reg, wr_byte};     // RULE5
    end
  end

  // One latch serves counter, capture and compare accesses.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      high_latch_reg <= 8'h00;
    end else if (wr_fire && (aw_addr_reg == tc_capcmp_pkg::ADDR_CAP_HIGH ||
                             aw_addr_reg == tc_capcmp_pkg::ADDR_CMPA_HIGH ||
                             aw_addr_reg == tc_capcmp_pkg::ADDR_CMPB_HIGH ||
                             aw_addr_reg == tc_capcmp_pkg::ADDR_CNT_HIGH)) begin
      high_latch_reg <= wr_byte;                         // RULE23 RULE25
    end else if (rd_fire && I_ARADDR == tc_capcmp_pkg::ADDR_CAP_LOW) begin
      high_latch_reg <= capture_register[15:8];          // RULE4
    end else if (rd_fire && I_ARADDR == tc_capcmp_pkg::ADDR_CNT_LOW) begin
      high_latch_reg <= I_COUNTER_VALUE[15:8];           // RULE25
    end
  end

  // Compare registers change by software writes and, when double buffered, take the buffer at top or bottom.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cmp_active_reg[0] <= tc_capcmp_pkg::CMP_RESET;
      cmp_active_reg[1] <= tc_capcmp_pkg::CMP_RESET;
      cmp_buf_reg[0]    <= tc_capcmp_pkg::CMP_RESET;
      cmp_buf_reg[1]    <= tc_capcmp_pkg::CMP_RESET;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr_fire && aw_addr_reg == ((u == 0) ? tc_capcmp_pkg::ADDR_CMPA_LOW
                                                : tc_capcmp_pkg::ADDR_CMPB_LOW)) begin
          if (dbl_buf) begin
            cmp_buf_reg[u] <= {high_latch_reg, wr_byte};     // RULE21 RULE23
          end else begin
            cmp_active_reg[u] <= {high_latch_reg, wr_byte};  // RULE21 RULE22
            cmp_buf_reg[u]    <= {high_latch_reg, wr_byte};
          end
        end else if (dbl_buf && (I_TOP || I_BOTTOM)) begin
          cmp_active_reg[u] <= cmp_buf_reg[u];               // RULE20
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // Waveform generator and counter outputs.
  //----------------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_WAVE_A            <= '0;
      O_WAVE_B            <= '0;
      O_WAVE_TOP          <= 1'b0;
      O_WAVE_BOTTOM       <= 1'b0;
      O_WAVEFORM_MODE_SEL <= 4'h0;
      O_CEILING           <= 16'hffff;
      O_CNT_WR            <= 1'b0;
      O_CNT_WDATA         <= 16'h0000;
    end else begin
      O_WAVE_A      <= '{match: cmp_set[0],
                         action: ctrl_reg[tc_capcmp_pkg::CTRL_OAA_LSB +: 2]}; // RULE18
      O_WAVE_B      <= '{match: cmp_set[1],
                         action: ctrl_reg[tc_capcmp_pkg::CTRL_OAB_LSB +: 2]}; // RULE18
      O_WAVE_TOP          <= I_TOP;
      O_WAVE_BOTTOM       <= I_BOTTOM;
      O_WAVEFORM_MODE_SEL <= mode;
      // Unit A or the capture register may set the ceiling.
      O_CEILING     <= cap_ceiling_mode ? capture_register :
                       (mode == tc_capcmp_pkg::MODE_NORMAL) ? 16'hffff
                                                            : cmp_active_reg[0]; // RULE19
      O_CNT_WR      <= wr_fire && aw_addr_reg == tc_capcmp_pkg::ADDR_CNT_LOW;
      O_CNT_WDATA   <= {high_latch_reg, wr_byte};
    end
  end

  //----------------------------------------------------------------------------
  // AXI4-Lite write channels; address and data taken in either order.
  //----------------------------------------------------------------------------
  assign O_AWREADY = !aw_hold_reg;
  assign O_WREADY  = !w_hold_reg;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      O_BVALID    <= 1'b0;
      O_BRESP     <= tc_capcmp_pkg::RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= I_WDATA;
        w_strb_reg <= I_WSTRB;
      end
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= (aw_addr_reg > tc_capcmp_pkg::ADDR_CNT_HIGH || aw_addr_reg[1:0] != 2'h0)
                    ? tc_capcmp_pkg::RESP_SLVERR : tc_capcmp_pkg::RESP_OKAY;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID    <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
      end
    end
  end

  // Control and mask registers.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_reg     <= tc_capcmp_pkg::CTRL_RESET;
      irq_mask_reg <= tc_capcmp_pkg::MASK_RESET;
    end else if (wr_fire) begin
      if (aw_addr_reg == tc_capcmp_pkg::ADDR_CTRL) begin
        if (w_strb_reg[0]) ctrl_reg[7:0]  <= w_data_reg[7:0];
        if (w_strb_reg[1]) ctrl_reg[15:8] <= w_data_reg[15:8];
      end
      if (aw_addr_reg == tc_capcmp_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= wr_byte[2:0];
      end
    end
  end

  //----------------------------------------------------------------------------
  // AXI4-Lite read channel.
  //----------------------------------------------------------------------------
  assign O_ARREADY = (rd_state_reg == tc_capcmp_pkg::RD_IDLE);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rd_state_reg <= tc_capcmp_pkg::RD_IDLE;
      O_RVALID     <= 1'b0;
      O_RDATA      <= 32'h0000_0000;
      O_RRESP      <= tc_capcmp_pkg::RESP_OKAY;
    end else begin
      case (rd_state_reg)
        tc_capcmp_pkg::RD_IDLE: begin
          if (rd_fire) begin
            rd_state_reg <= tc_capcmp_pkg::RD_RESP;
            O_RVALID     <= 1'b1;
            O_RRESP      <= tc_capcmp_pkg::RESP_OKAY;
            case (I_ARADDR)
              tc_capcmp_pkg::ADDR_CTRL:      O_RDATA <= {16'h0000, ctrl_reg};
              tc_capcmp_pkg::ADDR_IRQ_MASK:  O_RDATA <= {29'h0, irq_mask_reg};
              tc_capcmp_pkg::ADDR_FLAGS:     O_RDATA <= {29'h0, flag_reg};
              tc_capcmp_pkg::ADDR_CAP_LOW:   O_RDATA <= {24'h0, capture_register[7:0]};
              tc_capcmp_pkg::ADDR_CAP_HIGH:  O_RDATA <= {24'h0, high_latch_reg}; // RULE4
              tc_capcmp_pkg::ADDR_CMPA_LOW:  O_RDATA <= {24'h0, cmp_buf_reg[0][7:0]};
              tc_capcmp_pkg::ADDR_CMPA_HIGH: O_RDATA <= {24'h0, cmp_buf_reg[0][15:8]}; // RULE22
              tc_capcmp_pkg::ADDR_CMPB_LOW:  O_RDATA <= {24'h0, cmp_buf_reg[1][7:0]};
              tc_capcmp_pkg::ADDR_CMPB_HIGH: O_RDATA <= {24'h0, cmp_buf_reg[1][15:8]}; // RULE22
              tc_capcmp_pkg::ADDR_CNT_LOW:   O_RDATA <= {24'h0, I_COUNTER_VALUE[7:0]};
              tc_capcmp_pkg::ADDR_CNT_HIGH:  O_RDATA <= {24'h0, high_latch_reg};
              default: begin
                O_RDATA <= 32'h0000_0000;
                O_RRESP <= tc_capcmp_pkg::RESP_SLVERR;
              end
            endcase
          end
        end
        tc_capcmp_pkg::RD_RESP: begin
          if (I_RREADY) begin
            rd_state_reg <= tc_capcmp_pkg::RD_IDLE;
            O_RVALID     <= 1'b0;
          end
        end
        default: begin
          rd_state_reg <= tc_capcmp_pkg::RD_IDLE;
          O_RVALID     <= 1'b0;
        end
      endcase
    end
  end

endmodule : tc_capcmp

// ### hdl/tc_capcmp_pkg.sv
// Package with register map, field layout and timing constants of the capture/compare block.
//------------------------------------------------------------------------------
// Overview of operation
// [RULE1] Selected edge copies counter into capture register
// [RULE2] Capture flag set in the copy cycle
// [RULE3] Enabled flag interrupts; clears on ack or one
// [RULE4] Low-byte capture read latches the high byte
// [RULE5] Capture writes only in ceiling modes, high first
// [RULE6] Trigger source is pin or comparator output
// [RULE7] Both sources use the two-stage synchroniser
// [RULE8] Edge recognised 2.5 to 3.5 cycles late
// [RULE9] Filter changes after four equal samples
// [RULE10] Filter adds four system clock cycles
// [RULE11] Filter samples on the system clock
// [RULE12] Captures suppressed in capture-ceiling modes
// [RULE13] Port-driven pin triggers capture like external
// [RULE14] Each capture overwrites the capture register
// [RULE15] Software flips edge then clears flag
// [RULE16] Equality sets compare flag next timer tick
// [RULE17] Enabled compare flags interrupt; clear likewise
// [RULE18] Match, top and bottom feed waveform generator
// [RULE19] Compare unit A can set the ceiling
// [RULE20] PWM modes double buffer, update at top/bottom
// [RULE21] Software reaches buffer or active register
// [RULE22] Compare registers read directly, no latch
// [RULE23] Compare high byte latched, low write commits
// [RULE24] Counter write blocks next tick's matches
// [RULE25] One high-byte latch shared by all
//------------------------------------------------------------------------------
package tc_capcmp_pkg;

  //----------------------------------------------------------------------------
  // Register byte addresses (word aligned).
  //----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00; // Mode, edge, filter, source select.
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h04; // Interrupt enables.
  localparam logic [7:0] ADDR_FLAGS     = 8'h08; // Flags, write one to clear.
  localparam logic [7:0] ADDR_CAP_LOW   = 8'h0c; // Capture register low byte.
  localparam logic [7:0] ADDR_CAP_HIGH  = 8'h10; // Capture register high byte.
  localparam logic [7:0] ADDR_CMPA_LOW  = 8'h14; // Compare A low byte.
  localparam logic [7:0] ADDR_CMPA_HIGH = 8'h18; // Compare A high byte.
  localparam logic [7:0] ADDR_CMPB_LOW  = 8'h1c; // Compare B low byte.
  localparam logic [7:0] ADDR_CMPB_HIGH = 8'h20; // Compare B high byte.
  localparam logic [7:0] ADDR_CNT_LOW   = 8'h24; // Counter low byte (write blocks matches).
  localparam logic [7:0] ADDR_CNT_HIGH  = 8'h28; // Counter high byte (via latch).

  //----------------------------------------------------------------------------
  // Control register field positions.
  //----------------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0; // Waveform mode select, four bits.
  localparam int CTRL_EDGE_BIT = 4; // One selects rising edge.
  localparam int CTRL_NF_BIT   = 5; // Noise filter enable.
  localparam int CTRL_ACS_BIT  = 6; // Comparator capture select.
  localparam int CTRL_OAA_LSB  = 8; // Output action of unit A, two bits.
  localparam int CTRL_OAB_LSB  = 10; // Output action of unit B, two bits.

  // Flag and enable bit positions (same in mask and flag registers).
  localparam int FLAG_CAP  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;

  //----------------------------------------------------------------------------
  // Reset values and timing.
  //----------------------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [2:0]  MASK_RESET  = 3'h0;
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam int          FILT_SAMPLES = 4; // Equal samples needed by the filter.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Named waveform modes; of these only MODE_CTC_CAP makes the capture register the ceiling.
  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_CTC_A    = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hc;

  // Signals sent to the waveform generator for each compare unit.
  typedef struct packed {
    logic       match;  // One-cycle compare match.
    logic [1:0] action; // Output action select.
  } wave_req_t;

  // State of the read channel.
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;

endpackage : tc_capcmp_pkg

// ### verification/tc_trigger_model.sv
// Behavioural far-side model that drives the capture pin and the comparator output.
`timescale 1ns/1ps
module tc_trigger_model (
  // Clock and requested line levels.
  input  wire logic       i_clk,
  input  wire logic [1:0] i_lvl,
  // Trigger lines toward the block.
  output logic            o_pin,
  output logic            o_cmp
);
  // Lines change only after a clock edge, like a port output would.
  always_ff @(posedge i_clk) begin
    o_pin <= i_lvl[0];
    o_cmp <= i_lvl[1];
  end
endmodule : tc_trigger_model

// ### verification/tc_capcmp_asserts.sv
// Checker for bus handshakes, interrupt clearing and waveform timing of the block.
`timescale 1ns/1ps
module tc_capcmp_asserts (
  input wire logic I_CLK, I_RST, I_TOP, I_BOTTOM, I_AWVALID, O_AWREADY, I_BREADY, O_BVALID,
  input wire logic I_ARVALID, O_ARREADY, I_RREADY, O_RVALID, O_CAP_IRQ, I_CAP_IRQ_ACK,
  input wire logic O_WAVE_TOP, O_WAVE_BOTTOM, O_CNT_WR,
  input wire logic [31:0] O_RDATA,
  input wire tc_capcmp_pkg::wave_req_t O_WAVE_A
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  bvalid_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write response dropped early");
  rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  aw_block_a: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
    else $error("second write address accepted");
  read_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("read answer late");
  top_delay_a: assert property (!$past(I_RST) |-> O_WAVE_TOP == $past(I_TOP))
    else $error("top indication wrong");
  bottom_delay_a: assert property (!$past(I_RST) |-> O_WAVE_BOTTOM == $past(I_BOTTOM))
    else $error("bottom indication wrong");
  cnt_wr_pulse_a: assert property (O_CNT_WR |=> !O_CNT_WR)
    else $error("counter write pulse too long");
  cap_ack_clear_a: assert property (O_CAP_IRQ && I_CAP_IRQ_ACK |=> ##1 !O_CAP_IRQ)
    else $error("capture request not cleared");
  cover property (O_CAP_IRQ);
  cover property (O_WAVE_A.match);
  cover property (O_CNT_WR);
endmodule : tc_capcmp_asserts
bind tc_capcmp tc_capcmp_asserts u_chk (.*);

// ### verification/test_tc_capcmp.sv
// Self-checking testbench of the capture/compare block.
`timescale 1ns/1ps
module test_tc_capcmp;
  logic I_CLK = 0, I_RST = 1, I_TIMER_TICK = 0, I_TOP = 0, I_BOTTOM = 0, I_CAP_IRQ_ACK = 0;
  logic I_CMPA_IRQ_ACK = 0, I_CMPB_IRQ_ACK = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
  logic I_ARVALID = 0, I_RREADY = 0, I_CAPTURE_PIN, I_COMPARATOR_OUTPUT;
  logic [7:0] I_AWADDR = 0, I_ARADDR = 0;
  logic [31:0] I_WDATA = 0, O_RDATA, d;
  logic [3:0] I_WSTRB = 4'hf, O_WAVEFORM_MODE_SEL;
  logic [15:0] I_COUNTER_VALUE = 0, O_CEILING, O_CNT_WDATA;
  logic [1:0] O_BRESP, O_RRESP, lvl = 0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_CAP_IRQ, O_CMPA_IRQ, O_CMPB_IRQ;
  logic O_WAVE_TOP, O_WAVE_BOTTOM, O_CNT_WR, aw_ok, w_ok;
  tc_capcmp_pkg::wave_req_t O_WAVE_A, O_WAVE_B;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  tc_capcmp DUT (.*);
  tc_trigger_model u_src (.i_clk(I_CLK), .i_lvl(lvl), .o_pin(I_CAPTURE_PIN),
                          .o_cmp(I_COMPARATOR_OUTPUT));
  initial forever #10 I_CLK = ~I_CLK;
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Compares one value and counts it.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One write; address and data are each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    {aw_ok, w_ok} = 2'b00;
    I_AWADDR <= a;
    I_WDATA <= v;
    {I_AWVALID, I_WVALID, I_BREADY} <= 3'b111;
    do begin
      @(posedge I_CLK);
      aw_ok |= O_AWREADY;
      w_ok |= O_WREADY;
      if (aw_ok) I_AWVALID <= 1'b0;
      if (w_ok) I_WVALID <= 1'b0;
    end while (!(aw_ok && w_ok));
    do @(posedge I_CLK); while (!O_BVALID);
    I_BREADY <= 1'b0;
    @(posedge I_CLK);
  endtask : wr
  // One read with ready offered at once; checks data when the response is okay.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    I_ARADDR <= a;
    {I_ARVALID, I_RREADY} <= 2'b11;
    do @(posedge I_CLK); while (!O_ARREADY);
    I_ARVALID <= 1'b0;
    do @(posedge I_CLK); while (!O_RVALID);
    chk("rresp", {30'h0, r}, {30'h0, O_RRESP});
    if (r == tc_capcmp_pkg::RESP_OKAY) chk("rdata", e, O_RDATA);
    I_RREADY <= 1'b0;
    @(posedge I_CLK);
  endtask : rdc
  // Cuts a hang short.
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    I_COUNTER_VALUE <= 16'h1234;
    @(posedge I_CLK);
    wr(tc_capcmp_pkg::ADDR_CTRL, 32'h10);
    wr(tc_capcmp_pkg::ADDR_IRQ_MASK, 32'h3);
    lvl <= 2'b01;
    for (int i = 0; i < 20 && O_CAP_IRQ !== 1'b1; i++) @(posedge I_CLK);
    chk("cap irq", 1, O_CAP_IRQ);
    rdc(tc_capcmp_pkg::ADDR_CAP_LOW, 32'h34, tc_capcmp_pkg::RESP_OKAY);
    rdc(tc_capcmp_pkg::ADDR_CAP_HIGH, 32'h12, tc_capcmp_pkg::RESP_OKAY);
    I_CAP_IRQ_ACK <= 1'b1;
    @(posedge I_CLK);
    I_CAP_IRQ_ACK <= 1'b0;
    repeat (3) @(posedge I_CLK);
    chk("cap irq", 0, O_CAP_IRQ);
    wr(tc_capcmp_pkg::ADDR_CTRL, 32'h0);
    lvl <= 2'b00;
    repeat (7) @(posedge I_CLK);
    chk("cap irq", 1, O_CAP_IRQ);
    wr(tc_capcmp_pkg::ADDR_FLAGS, 32'h1);
    rdc(tc_capcmp_pkg::ADDR_FLAGS, 32'h0, tc_capcmp_pkg::RESP_OKAY);
    wr(tc_capcmp_pkg::ADDR_CMPA_HIGH, 32'h56);
    wr(tc_capcmp_pkg::ADDR_CMPA_LOW, 32'h78);
    rdc(tc_capcmp_pkg::ADDR_CMPA_LOW, 32'h78, tc_capcmp_pkg::RESP_OKAY);
    rdc(tc_capcmp_pkg::ADDR_CMPA_HIGH, 32'h56, tc_capcmp_pkg::RESP_OKAY);
    wr(tc_capcmp_pkg::ADDR_CNT_LOW, 32'h00);
    I_COUNTER_VALUE <= 16'h5678;
    I_TIMER_TICK <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk("cmpa blk", 0, O_CMPA_IRQ);
    for (int i = 0; i < 20 && O_CMPA_IRQ !== 1'b1; i++) @(posedge I_CLK);
    chk("cmpa irq", 1, O_CMPA_IRQ);
    rdc(8'h2c, 32'h0, tc_capcmp_pkg::RESP_SLVERR);
    wrap_up();
  end
endmodule : test_tc_capcmp
